/* File: design/pdw_pkg.sv */
package pdw_pkg;

	// Duty resolution in bits; the period is two to this power
	localparam int PDW_RES_BITS = 10;
	// Timer clock figures, in MHz
	localparam int PDW_TCLK_FAST_MHZ = 32;
	localparam int PDW_TCLK_SLOW_MHZ = 16;
	// Waveform table depth used by the sequencer
	localparam int PDW_TABLE_DEPTH = 128;

	// Register byte offsets
	localparam logic [7:0] PDW_OFS_CTRL = 8'h00;
	localparam logic [7:0] PDW_OFS_CMP = 8'h04;
	localparam logic [7:0] PDW_OFS_ACTIVE = 8'h08;
	localparam logic [7:0] PDW_OFS_COUNT = 8'h0C;
	localparam logic [7:0] PDW_OFS_STATUS = 8'h10;
	localparam logic [7:0] PDW_OFS_MASK = 8'h14;

	// Control field positions
	localparam int PDW_CTRL_RUN = 0;
	localparam int PDW_CTRL_SHADOW = 1;
	localparam int PDW_CTRL_SLOW = 2;
	// Status field positions
	localparam int PDW_ST_ZERO = 0;
	localparam int PDW_ST_CMPDN = 1;

	// Reset values
	localparam logic [2:0] PDW_CTRL_RST = 3'h2;
	localparam logic [1:0] PDW_MASK_RST = 2'h0;

	// AXI responses
	localparam logic [1:0] PDW_RESP_OKAY = 2'h0;
	localparam logic [1:0] PDW_RESP_SLVERR = 2'h2;

	// Events produced by the counter core each timer tick
	typedef struct packed {
		logic zero;
		logic cmpDown;
	} pdw_event_type;

	// Write side states of the bus slave
	typedef enum logic [1:0] {
		PDW_WR_IDLE = 2'b00,
		PDW_WR_RESP = 2'b01
	} pdw_wr_state_type;

endpackage

/* File: design/pdw_counter.sv */
`timescale 1ns/1ns
// Edge-aligned down-counter with shadowed compare
module pdw_counter
	import pdw_pkg::*;
#(
	parameter int RES_BITS = PDW_RES_BITS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Control
	input wire logic tick,
	input wire logic run,
	input wire logic shadowEn,
	input wire logic [RES_BITS-1:0] shadowCmp,
	// State
	output logic [RES_BITS-1:0] count,
	output logic [RES_BITS-1:0] activeCmp,
	output logic pwmLevel,
	output pdw_event_type events
);

	// Period minus one is all ones for a power-of-two period
	localparam logic [RES_BITS-1:0] TOP = '1;

	logic [RES_BITS-1:0] next_count;
	logic [RES_BITS-1:0] next_activeCmp;
	logic next_pwmLevel;
	pdw_event_type next_events;
	logic loadPending; // Zero seen; copy shadow on following tick
	logic next_loadPending;

	// Next-state of count, compare and output
	always_comb begin
		next_count = count;
		next_activeCmp = activeCmp;
		next_pwmLevel = pwmLevel;
		next_loadPending = loadPending;
		next_events = '0;
		if (!shadowEn) begin
			// Direct mode: the compare follows software at once
			next_activeCmp = shadowCmp;
		end
		if (run && tick) begin
			next_count = (count == '0) ? TOP : count - 1'b1;
			// period of two to the resolution
			next_events.zero = (count == '0);
			// compare-down event when passing the compare
			next_events.cmpDown = (next_count == activeCmp) &&
				(count != '0);
			// shadow moves one tick after zero
			if (shadowEn && loadPending) begin
				next_activeCmp = shadowCmp;
			end
			next_loadPending = (count == '0);
			next_pwmLevel = next_count < next_activeCmp;
		end
	end

	// Registers only
	always_ff @(posedge clk) begin
		if (!resetn) begin
			count <= TOP;
			activeCmp <= '0;
			pwmLevel <= 1'b0;
			loadPending <= 1'b0;
			events <= '0;
		end else begin
			count <= next_count;
			activeCmp <= next_activeCmp;
			pwmLevel <= next_pwmLevel;
			loadPending <= next_loadPending;
			events <= next_events;
		end
	end

	// active compare holds inside a period under shadow
	chk_shadow_hold: assert property (
		@(posedge clk) disable iff (!resetn)
		shadowEn && $past(shadowEn) && !$past(loadPending)
		|-> $stable(activeCmp))
		else $error("active compare changed mid-period");
	chk_reload_top: assert property (
		@(posedge clk) disable iff (!resetn)
		$past(run && tick) && $past(count) == '0 |-> count == TOP)
		else $error("counter did not reload to top");

endmodule

/* File: design/pdw_top.sv */
`timescale 1ns/1ns
// Operation
// - Ten-bit resolution, 1024-tick period
// - Period equals two to resolution; 32/16 MHz
// - Edge-aligned; with shadow on, compare changes only after zero
// - Shadowed compare never changes mid-period
// - Down count; event when passing compare
// - Shadow copied one tick after zero
module pdw_top
	import pdw_pkg::*;
#(
	parameter int RES_BITS = PDW_RES_BITS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// PWM output and interrupt
	output logic pwmOut,
	output logic irq
);

	// Divider for the slow 16 MHz timer clock from 32 MHz ticks
	localparam int SLOW_DIV = PDW_TCLK_FAST_MHZ / PDW_TCLK_SLOW_MHZ;

	// Registers
	logic [2:0] ctrl;
	logic [RES_BITS-1:0] shadowCmp;
	logic [1:0] status;
	logic [1:0] mask;
	logic tickPhase; // Halves the tick rate in slow mode
	logic [2:0] next_ctrl;
	logic [RES_BITS-1:0] next_shadowCmp;
	logic [1:0] next_status;
	logic [1:0] next_mask;
	logic next_tickPhase;
	logic next_irq;

	// Bus slave state
	pdw_wr_state_type wrState, next_wrState;
	logic awHeld, wHeld, next_awHeld, next_wHeld;
	logic [7:0] awAddr, next_awAddr;
	logic [31:0] wData, next_wData;
	logic [3:0] wStrb, next_wStrb;
	logic next_awready, next_wready, next_bvalid, next_arready;
	logic next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;

	// Core signals
	logic tick;
	logic [RES_BITS-1:0] count, activeCmp;
	logic pwmLevel;
	pdw_event_type events;

	// Decode shared by both channels
	function automatic logic isMapped(input logic [7:0] a);
		isMapped = (a == PDW_OFS_CTRL) || (a == PDW_OFS_CMP) ||
			(a == PDW_OFS_ACTIVE) || (a == PDW_OFS_COUNT) ||
			(a == PDW_OFS_STATUS) || (a == PDW_OFS_MASK);
	endfunction

	// one tick per clock at 32 MHz, every other at 16 MHz
	assign tick = !ctrl[PDW_CTRL_SLOW] || tickPhase;

	pdw_counter #(.RES_BITS(RES_BITS)) pdw_counter_inst (
		.clk(clk),
		.resetn(resetn),
		.tick(tick),
		.run(ctrl[PDW_CTRL_RUN]),
		.shadowEn(ctrl[PDW_CTRL_SHADOW]),
		.shadowCmp(shadowCmp),
		.count(count),
		.activeCmp(activeCmp),
		.pwmLevel(pwmLevel),
		.events(events)
	);

	// Write channel: takes address and data in either order
	always_comb begin
		next_wrState = wrState;
		next_awHeld = awHeld;
		next_wHeld = wHeld;
		next_awAddr = awAddr;
		next_wData = wData;
		next_wStrb = wStrb;
		next_awready = 1'b0;
		next_wready = 1'b0;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_ctrl = ctrl;
		next_shadowCmp = shadowCmp;
		next_mask = mask;
		next_status = status;
		next_tickPhase = (SLOW_DIV > 1) ? !tickPhase : 1'b1;
		case (wrState)
			PDW_WR_IDLE: begin
				if (s_axi_awvalid && s_axi_awready) begin
					next_awHeld = 1'b1;
					next_awAddr = s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					next_wHeld = 1'b1;
					next_wData = s_axi_wdata;
					next_wStrb = s_axi_wstrb;
				end
				// Ready pulses one cycle while the channel is empty
				next_awready = !next_awHeld && s_axi_awvalid &&
					!s_axi_awready;
				next_wready = !next_wHeld && s_axi_wvalid &&
					!s_axi_wready;
				if (awHeld && wHeld) begin
					next_awHeld = 1'b0;
					next_wHeld = 1'b0;
					next_bvalid = 1'b1;
					next_bresp = isMapped(awAddr) ? PDW_RESP_OKAY :
						PDW_RESP_SLVERR;
					next_wrState = PDW_WR_RESP;
					if (awAddr == PDW_OFS_CTRL && wStrb[0]) begin
						next_ctrl = wData[2:0];
					end
					// software writes go to the shadow
					if (awAddr == PDW_OFS_CMP) begin
						if (wStrb[0]) begin
							next_shadowCmp[7:0] = wData[7:0];
						end
						if (wStrb[1]) begin
							next_shadowCmp[RES_BITS-1:8] =
								wData[RES_BITS-1:8];
						end
					end
					if (awAddr == PDW_OFS_MASK && wStrb[0]) begin
						next_mask = wData[1:0];
					end
					if (awAddr == PDW_OFS_STATUS && wStrb[0]) begin
						next_status = status & ~wData[1:0];
					end
				end
			end
			PDW_WR_RESP: begin
				if (s_axi_bready) begin
					next_bvalid = 1'b0;
					next_wrState = PDW_WR_IDLE;
				end
			end
			default: begin
				next_wrState = PDW_WR_IDLE;
			end
		endcase
		// Hardware set wins over a software clear in the same cycle
		next_status[PDW_ST_ZERO] = next_status[PDW_ST_ZERO] |
			events.zero;
		next_status[PDW_ST_CMPDN] = next_status[PDW_ST_CMPDN] |
			events.cmpDown;
		next_irq = |(next_status & next_mask);
	end

	// Read channel: one read at a time, data one cycle after address
	always_comb begin
		next_arready = 1'b0;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				next_rvalid = 1'b0;
			end
		end else if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = isMapped(s_axi_araddr) ? PDW_RESP_OKAY :
				PDW_RESP_SLVERR;
			case (s_axi_araddr)
				PDW_OFS_CTRL: next_rdata = {29'h0, ctrl};
				PDW_OFS_CMP: next_rdata = {22'h0, shadowCmp};
				PDW_OFS_ACTIVE: next_rdata = {22'h0, activeCmp};
				PDW_OFS_COUNT: next_rdata = {22'h0, count};
				PDW_OFS_STATUS: next_rdata = {30'h0, status};
				PDW_OFS_MASK: next_rdata = {30'h0, mask};
				default: next_rdata = 32'h0;
			endcase
		end else begin
			next_arready = s_axi_arvalid;
		end
	end

	// Register everything
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wrState <= PDW_WR_IDLE;
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 8'h00;
			wData <= 32'h0;
			wStrb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= PDW_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= PDW_RESP_OKAY;
			ctrl <= PDW_CTRL_RST;
			shadowCmp <= '0;
			status <= 2'h0;
			mask <= PDW_MASK_RST;
			tickPhase <= 1'b0;
			irq <= 1'b0;
			pwmOut <= 1'b0;
		end else begin
			wrState <= next_wrState;
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			awAddr <= next_awAddr;
			wData <= next_wData;
			wStrb <= next_wStrb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			ctrl <= next_ctrl;
			shadowCmp <= next_shadowCmp;
			status <= next_status;
			mask <= next_mask;
			tickPhase <= next_tickPhase;
			irq <= next_irq;
			pwmOut <= pwmLevel;
		end
	end

	chk_cmpdn_sticky: assert property (
		@(posedge clk) disable iff (!resetn)
		events.cmpDown |=> status[PDW_ST_CMPDN])
		else $error("compare event not recorded");
	// no second zero event within 8 clocks of one at full rate
	chk_period_len: assert property (
		@(posedge clk) disable iff (!resetn)
		events.zero && !ctrl[PDW_CTRL_SLOW] && ctrl[PDW_CTRL_RUN]
		&& $stable(ctrl) |=> !events.zero [*8])
		else $error("zero events too close");
	// slow mode ticks every second clock
	// A switch back to full rate may bring a tick at once
	chk_slow_tick: assert property (
		@(posedge clk) disable iff (!resetn)
		ctrl[PDW_CTRL_SLOW] && $past(ctrl[PDW_CTRL_SLOW]) && tick
		|=> !(tick && ctrl[PDW_CTRL_SLOW]))
		else $error("slow tick too fast");
	// pad output follows core level one cycle later
	chk_pwm_follow: assert property (
		@(posedge clk) disable iff (!resetn)
		pwmOut == $past(pwmLevel))
		else $error("pwm output lags wrong");
	chk_irq_level: assert property (
		@(posedge clk) disable iff (!resetn)
		irq == |($past(next_status) & $past(next_mask)))
		else $error("interrupt level wrong");
	// shadow register holds without a write
	chk_shadow_keep: assert property (
		@(posedge clk) disable iff (!resetn)
		!(awHeld && wHeld) |=> $stable(shadowCmp))
		else $error("shadow changed without write");
	// shadow lands on the tick after the zero tick
	chk_shadow_load: assert property (
		@(posedge clk) disable iff (!resetn)
		events.zero && ctrl[PDW_CTRL_SHADOW] && ctrl[PDW_CTRL_RUN]
		&& tick |=> activeCmp == $past(shadowCmp))
		else $error("shadow not loaded after zero");

	// Main scenarios worth seeing in a run
	cov_zero: cover property (@(posedge clk) events.zero);
	cov_cmpdn: cover property (@(posedge clk) events.cmpDown);
	cov_irq: cover property (@(posedge clk) irq);
	cov_slow: cover property (@(posedge clk) ctrl[PDW_CTRL_SLOW] && tick);
	cov_load: cover property (@(posedge clk)
		ctrl[PDW_CTRL_SHADOW] && $changed(activeCmp));

endmodule

/* File: verif/pdw_rc_filter.sv */
`timescale 1ns/1ns
// First-order low-pass model of the resistor and capacitor on the pin
module pdw_rc_filter
	import pdw_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Filter input and smoothed level
	input wire logic pwm,
	output logic [15:0] level
);
	// Leaky integrator; the shift sets the time constant in clocks
	logic [15:0] next_level;

	// Each clock the level moves one sixteenth towards the input
	always_comb begin
		next_level = level - (level >> 4) + (pwm ? 16'h0FFF : 16'h0000);
	end

	// Registered so the level never changes between edges
	always_ff @(posedge clk) begin
		if (!resetn) begin
			level <= 16'h0000;
		end else begin
			level <= next_level;
		end
	end
endmodule

/* File: verif/pwm_dac_waveform_timer_test.sv */
`timescale 1ns/1ns
// Counts a comparison and reports a mismatch at once
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
	error_cnt++; $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module pwm_dac_waveform_timer_test;
	import pdw_pkg::*;
	// Clock, reset and bus signals
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, pwmOut, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] data, prev;
	logic [15:0] level;
	int error_cnt = 0, checks_done = 0, idx;
	// Waveform monitor state
	int cyc = 0, riseAt = 0, hiRun = 0, periodLen = 0, highLen = 0, falls = 0;
	logic pwmPrev = 1'b0;
	// Register reset rows: address, read data, response
	logic [7:0] rowAddr [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
	logic [31:0] rowData [7] = '{32'(PDW_CTRL_RST), 32'h0, 32'h0, 32'h3FF,
		32'h0, 32'(PDW_MASK_RST), 32'h0};
	logic [1:0] rowResp [7] = '{PDW_RESP_OKAY, PDW_RESP_OKAY, PDW_RESP_OKAY,
		PDW_RESP_OKAY, PDW_RESP_OKAY, PDW_RESP_OKAY, PDW_RESP_SLVERR};

	// Device under test and the filter on its pin
	pdw_top pdw_top_inst (.clk(clk), .resetn(resetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .pwmOut(pwmOut), .irq(irq));
	pdw_rc_filter pdw_rc_filter_inst (.clk(clk), .resetn(resetn),
		.pwm(pwmOut), .level(level));

	// 100 MHz clock
	always #5 clk = ~clk;

	// Measures period between rises and width of each high pulse
	always @(posedge clk) begin
		cyc <= cyc + 1;
		pwmPrev <= pwmOut;
		if (pwmOut) hiRun <= hiRun + 1;
		if (pwmOut && !pwmPrev) begin
			periodLen <= cyc - riseAt;
			riseAt <= cyc;
			hiRun <= 1;
		end
		if (!pwmOut && pwmPrev) begin
			highLen <= hiRun;
			falls <= falls + 1;
		end
	end

	// Write: address and data offered together, each dropped when taken
	task automatic axWr(input logic [7:0] a, input logic [31:0] d);
		logic awDone, wDone;
		awDone = 1'b0;
		wDone = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(awDone && wDone)) begin
			@(posedge clk);
			if (s_axi_awready === 1'b1) begin
				awDone = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1) begin
				wDone = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// Read: response data taken at the edge where rvalid is seen
	task automatic axRd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		data = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Walks the reset table, unmapped row included
	task automatic checkRows();
		for (int i = 0; i < 7; i++) begin
			axRd(rowAddr[i]);
			`CHK({data, resp}, {rowData[i], rowResp[i]})
		end
	endtask

	// Waits for a number of falling pulse edges
	task automatic waitFalls(input int n);
		int f0;
		f0 = falls;
		while (falls < f0 + n) @(posedge clk);
	endtask

	// Prints the counts and the verdict, then ends the run
	task automatic wrap_up();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Watchdog sized well past the longest expected run
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		wrap_up();
	end

	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		checkRows();
		// Writes to an unmapped place are refused
		axWr(8'h18, 32'h1);
		`CHK(resp, PDW_RESP_SLVERR)
		axWr(PDW_OFS_CMP, 32'h100);
		axWr(PDW_OFS_CTRL, 32'h3);
		axRd(PDW_OFS_ACTIVE);
		`CHK(data, 32'h0)
		waitFalls(2);
		`CHK(periodLen, 1024)
		`CHK(highLen, 256)
		// Slow timer clock doubles the period
		axWr(PDW_OFS_CTRL, 32'h7);
		waitFalls(3);
		`CHK(periodLen, 2048)
		`CHK(highLen, 512)
		axWr(PDW_OFS_CTRL, 32'h3);
		// Compare-down interrupt: raise, clear, mask
		axWr(PDW_OFS_MASK, 32'h2);
		while (irq !== 1'b1) @(posedge clk);
		axRd(PDW_OFS_STATUS);
		`CHK(data[PDW_ST_CMPDN], 1'b1)
		axWr(PDW_OFS_STATUS, 32'h3);
		@(posedge clk);
		`CHK(irq, 1'b0)
		axWr(PDW_OFS_MASK, 32'h0);
		waitFalls(1);
		`CHK(irq, 1'b0)
		// Filter has charged through the high part of the pulse
		`CHK(level > 16'h8000, 1'b1)
		axWr(PDW_OFS_MASK, 32'h2);
		// Drop flags left from earlier periods so the first wait is fresh
		axWr(PDW_OFS_STATUS, 32'h3);
		// Controller feeds table samples across the index wrap
		prev = 32'h100;
		idx = 126;
		for (int k = 0; k < 4; k++) begin
			while (irq !== 1'b1) @(posedge clk);
			axRd(PDW_OFS_ACTIVE);
			`CHK(data, prev)
			// scaled sample written on the event
			axWr(PDW_OFS_CMP, 32'(64 + idx * 7));
			axRd(PDW_OFS_ACTIVE);
			`CHK(data, prev)
			axWr(PDW_OFS_STATUS, 32'h3);
			prev = 32'(64 + idx * 7);
			idx = (idx + 1) % PDW_TABLE_DEPTH;
		end
		// Shadow off: active compare follows at once
		axWr(PDW_OFS_CTRL, 32'h1);
		axWr(PDW_OFS_CMP, 32'h55);
		axRd(PDW_OFS_ACTIVE);
		`CHK(data, 32'h55)
		// Reset in mid-run restores every register
		resetn <= 1'b0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		checkRows();
		wrap_up();
	end
endmodule
